// >>> tb/fap_top_bench.sv
// self-checking bench for the flash address and protect block
`include "fap_defines.svh"
module fap_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import fap_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic por_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    fap_cmd_t flash_cmd;
    logic [23:0] protect_boundary;
    logic protect_unlocked;
    logic [31:0] rd;
    logic er;
    int bad_count = 0;
    int n_compared = 0;
    fap_top u_fap_top (.pclk(pclk), .presetn(presetn), .por_n(por_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flash_cmd(flash_cmd),
        .protect_boundary(protect_boundary),
        .protect_unlocked(protect_unlocked));
    // free-running bus clock
    initial begin
        forever #5 pclk = ~pclk;
    end
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer; pready, data and error taken at the rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic unlock_write(input logic [31:0] d);
        apb(1'b1, 12'h00C, `FAP_KEY1);
        apb(1'b1, 12'h00C, `FAP_KEY2);
        apb(1'b1, 12'h004, d);
    endtask
    task automatic test_reset_values();
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h00000000);
        chk({31'h0, er}, 32'h00000000);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h80000000);
        chk({31'h0, protect_unlocked}, 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        chk({31'h0, er}, 32'h00000001);
        chk(rd, 32'h00000000);
        $display("test reset values done");
    endtask
    task automatic test_op_masks();
        logic [3:0] opc [4] = '{4'h2, 4'h3, 4'h4, 4'h5};
        logic [31:0] msk [4] = '{32'hFFFFFFF8, 32'hFFFFFF00,
                                 32'hFFFFF800, 32'h00000000};
        logic [1:0] knd [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
        apb(1'b1, 12'h000, 32'hFFFFFFFF);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'hFFFFFFFF);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 12'h008, {28'h0, opc[i]});
            repeat (3) @(posedge pclk);
            chk(flash_cmd.addr, msk[i]);
            chk({30'h0, flash_cmd.kind}, {30'h0, knd[i]});
        end
        $display("test op masks done");
    endtask
    task automatic test_protect();
        apb(1'b1, 12'h004, 32'h80000800);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h80000000);
        unlock_write(32'h80000800);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h80000800);
        chk({8'h00, protect_boundary}, 32'h00000800);
        chk({31'h0, protect_unlocked}, 32'h1);
        apb(1'b1, 12'h008, 32'h00000004);
        apb(1'b1, 12'h000, 32'h00000FFF);
        repeat (3) @(posedge pclk);
        chk({31'h0, flash_cmd.protected_hit}, 32'h1);
        apb(1'b1, 12'h000, 32'h00001000);
        repeat (3) @(posedge pclk);
        chk({31'h0, flash_cmd.protected_hit}, 32'h0);
        apb(1'b1, 12'h000, 32'h00000000);
        repeat (3) @(posedge pclk);
        chk({31'h0, flash_cmd.protected_hit}, 32'h1);
        unlock_write(32'h00000000);
        repeat (3) @(posedge pclk);
        chk({31'h0, flash_cmd.protected_hit}, 32'h0);
        chk({31'h0, protect_unlocked}, 32'h0);
        unlock_write(32'h80001000);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h00000000);
        chk({8'h00, protect_boundary}, 32'h00000000);
        $display("test protect done");
    endtask
    task automatic test_reset_sources();
        apb(1'b1, 12'h000, 32'h12345678);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h12345678);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h80000000);
        @(posedge pclk);
        presetn <= 1'b0;
        por_n <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h00000000);
        $display("test reset sources done");
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
        test_reset_values();
        test_op_masks();
        test_protect();
        test_reset_sources();
        complete_run();
    end
    // hang guard, far beyond the few hundred cycles needed
    initial begin
        #200000;
        bad_count++;
        complete_run();
    end
endmodule

// >>> verilog/fap_defines.svh
// register offsets, reset values, key codes and field positions
`ifndef FAP_DEFINES_SVH
`define FAP_DEFINES_SVH
`define FAP_OFS_ADDR 12'h000
`define FAP_OFS_PROT 12'h004
`define FAP_OFS_CTRL 12'h008
`define FAP_OFS_KEY 12'h00C
`define FAP_ADDR_RST 32'h00000000
`define FAP_BOUND_RST 24'h000000
`define FAP_CTRL_RST 4'h0
`define FAP_UNLOCK_RST 1'b1
`define FAP_UNLOCK_BIT 31
`define FAP_BOUND_MSB 23
`define FAP_OPSEL_MSB 3
// unlock key words, values arbitrary
`define FAP_KEY1 32'h5A5A0001
`define FAP_KEY2 32'hA5A50002
// operation select codes
`define FAP_OPC_DWORD 4'h2
`define FAP_OPC_ROW 4'h3
`define FAP_OPC_PAGE 4'h4
// ignored low address bits per operation
`define FAP_PAGE_LSB 11
`define FAP_PAGE_MASK 32'hFFFFF800
`define FAP_ROW_MASK 32'hFFFFFF00
`define FAP_DWORD_MASK 32'hFFFFFFF8
`endif

// >>> verilog/fap_pkg.sv
// types shared by the flash address and protect block
package fap_pkg;
    typedef enum logic [1:0] {
        FAP_OP_NONE,
        FAP_OP_PAGE_ERASE,
        FAP_OP_ROW_PROG,
        FAP_OP_DWORD_PROG
    } fap_op_t;

    typedef enum logic [1:0] {
        FAP_KEY_IDLE,
        FAP_KEY_HALF,
        FAP_KEY_OPEN
    } fap_key_t;

    typedef struct packed {
        fap_op_t kind;
        logic [31:0] addr;
        logic protected_hit;
    } fap_cmd_t;
endpackage

// >>> verilog/fap_top.sv
// flash target address and program flash write protect, apb slave
// Function
// - 32-bit read/write target address register, resets to zero.
// - page erase uses target address with bits 10..0 ignored.
// - row program uses target address with bits 7..0 ignored.
// - double-word program ignores bits 2..0; software gives aligned address.
// - any other operation select value disregards the target address.
// - target address cleared only by power-on reset, not other resets.
// - unlock flag permits protect writes; software only clears, reset sets.
// - zero boundary disables write protection for whole program flash.
// - boundary inside a page protects that page and all below.
// - protect register writes accepted only after key unlock sequence.
//
// Design decisions made here: the APB register port and the address map.
`include "fap_defines.svh"
module fap_top import fap_pkg::*; (
    // clock and resets
    input wire logic pclk,
    input wire logic presetn,
    input wire logic por_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // to erase and program engine
    output fap_cmd_t flash_cmd,
    output logic [23:0] protect_boundary,
    output logic protect_unlocked
);
    logic [31:0] addr_ff, nxt_addr;
    logic [23:0] bound_ff, nxt_bound;
    logic unlock_ff, nxt_unlock;
    logic [3:0] ctrl_ff, nxt_ctrl;
    fap_key_t key_ff, nxt_key;
    fap_cmd_t cmd_ff, nxt_cmd;
    logic done_ff, nxt_done;
    logic [31:0] rdata_ff, nxt_rdata;
    logic err_ff, nxt_err;
    logic acc, xfer, wr;
    logic sel_addr, sel_prot, sel_ctrl, sel_key, mapped;

    // bus phase and address decode
    assign acc = psel & penable;
    assign xfer = acc & done_ff;
    assign wr = xfer & pwrite & mapped;
    assign sel_addr = (paddr == `FAP_OFS_ADDR);
    assign sel_prot = (paddr == `FAP_OFS_PROT);
    assign sel_ctrl = (paddr == `FAP_OFS_CTRL);
    assign sel_key = (paddr == `FAP_OFS_KEY);
    assign mapped = sel_addr | sel_prot | sel_ctrl | sel_key;
    assign pready = xfer;
    assign pslverr = xfer & err_ff;
    assign prdata = rdata_ff;
    assign flash_cmd = cmd_ff;
    assign protect_boundary = bound_ff;
    assign protect_unlocked = unlock_ff;

    // access phase: one wait state, read data captured into flops
    always_comb begin
        nxt_done = acc & ~done_ff;
        nxt_rdata = rdata_ff;
        nxt_err = err_ff;
        if (acc && !done_ff) begin
            nxt_err = ~mapped;
            nxt_rdata = 32'h00000000;
            if (!pwrite) begin
                if (sel_addr) begin
                    nxt_rdata = addr_ff;
                end else if (sel_prot) begin
                    nxt_rdata[`FAP_UNLOCK_BIT] = unlock_ff;
                    nxt_rdata[`FAP_BOUND_MSB:0] = bound_ff;
                end else if (sel_ctrl) begin
                    nxt_rdata[`FAP_OPSEL_MSB:0] = ctrl_ff;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            err_ff <= 1'b0;
        end else begin
            done_ff <= nxt_done;
            rdata_ff <= nxt_rdata;
            err_ff <= nxt_err;
        end
    end

    // target address, kept across all but power-on reset
    always_comb begin
        nxt_addr = addr_ff;
        if (wr && sel_addr) begin
            nxt_addr = pwdata;
        end
    end

    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            addr_ff <= `FAP_ADDR_RST;
        end else begin
            addr_ff <= nxt_addr;
        end
    end

    // key sequence: key1 then key2 opens one protect write
    always_comb begin
        nxt_key = key_ff;
        if (wr) begin
            case (key_ff)
                FAP_KEY_HALF: begin
                    if (sel_key && pwdata == `FAP_KEY2) begin
                        nxt_key = FAP_KEY_OPEN;
                    end else begin
                        nxt_key = FAP_KEY_IDLE; // wrong second key
                    end
                end
                default: begin
                    nxt_key = FAP_KEY_IDLE; // any other write closes it
                end
            endcase
            if (sel_key && pwdata == `FAP_KEY1) begin
                nxt_key = FAP_KEY_HALF; // first key always restarts
            end
        end
    end

    // protect register and operation select
    always_comb begin
        nxt_bound = bound_ff;
        nxt_unlock = unlock_ff;
        nxt_ctrl = ctrl_ff;
        if (wr && sel_prot && key_ff == FAP_KEY_OPEN &&
            unlock_ff) begin
            nxt_unlock = unlock_ff & pwdata[`FAP_UNLOCK_BIT];
            nxt_bound = pwdata[`FAP_BOUND_MSB:0];
        end
        if (wr && sel_ctrl) begin
            nxt_ctrl = pwdata[`FAP_OPSEL_MSB:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_ff <= FAP_KEY_IDLE;
            bound_ff <= `FAP_BOUND_RST;
            unlock_ff <= `FAP_UNLOCK_RST;
            ctrl_ff <= `FAP_CTRL_RST;
        end else begin
            key_ff <= nxt_key;
            bound_ff <= nxt_bound;
            unlock_ff <= nxt_unlock;
            ctrl_ff <= nxt_ctrl;
        end
    end

    // command to the engine: masked address and protect check
    always_comb begin
        nxt_cmd.kind = FAP_OP_NONE;
        nxt_cmd.addr = 32'h00000000;
        case (ctrl_ff)
            `FAP_OPC_PAGE: begin
                nxt_cmd.kind = FAP_OP_PAGE_ERASE;
                nxt_cmd.addr = addr_ff & `FAP_PAGE_MASK;
            end
            `FAP_OPC_ROW: begin
                nxt_cmd.kind = FAP_OP_ROW_PROG;
                nxt_cmd.addr = addr_ff & `FAP_ROW_MASK;
            end
            `FAP_OPC_DWORD: begin
                nxt_cmd.kind = FAP_OP_DWORD_PROG;
                nxt_cmd.addr = addr_ff & `FAP_DWORD_MASK;
            end
            default: begin
                nxt_cmd.kind = FAP_OP_NONE;
                nxt_cmd.addr = 32'h00000000;
            end
        endcase
        nxt_cmd.protected_hit = (nxt_cmd.kind != FAP_OP_NONE) &&
            (bound_ff != `FAP_BOUND_RST) &&
            (nxt_cmd.addr[23:`FAP_PAGE_LSB] <=
             bound_ff[23:`FAP_PAGE_LSB]);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_ff <= '0;
        end else begin
            cmd_ff <= nxt_cmd;
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_addr_write_lands: assert property (
        pready && pwrite && sel_addr |=> addr_ff == $past(pwdata))
        else $error("target address write lost");
    a_page_erase_mask: assert property (
        ctrl_ff == `FAP_OPC_PAGE |=> cmd_ff.kind == FAP_OP_PAGE_ERASE &&
        cmd_ff.addr[10:0] == 11'h000 &&
        cmd_ff.addr[31:11] == $past(addr_ff[31:11]))
        else $error("page erase address wrong");
    a_row_prog_mask: assert property (
        ctrl_ff == `FAP_OPC_ROW |=> cmd_ff.kind == FAP_OP_ROW_PROG &&
        cmd_ff.addr[7:0] == 8'h00 &&
        cmd_ff.addr[31:8] == $past(addr_ff[31:8]))
        else $error("row program address wrong");
    a_dword_mask: assert property (
        ctrl_ff == `FAP_OPC_DWORD |=> cmd_ff.kind == FAP_OP_DWORD_PROG &&
        cmd_ff.addr[2:0] == 3'h0 &&
        cmd_ff.addr[31:3] == $past(addr_ff[31:3]))
        else $error("double word address wrong");
    a_other_op_none: assert property (
        ctrl_ff != `FAP_OPC_PAGE && ctrl_ff != `FAP_OPC_ROW &&
        ctrl_ff != `FAP_OPC_DWORD |=> cmd_ff.kind == FAP_OP_NONE &&
        cmd_ff.addr == 32'h00000000 && !cmd_ff.protected_hit)
        else $error("address used for other op");
    a_addr_keeps_reset: assert property (
        @(posedge pclk) disable iff (!por_n)
        !presetn |=> addr_ff == $past(addr_ff))
        else $error("address changed in system reset");
    a_unlock_no_set: assert property (
        !unlock_ff |=> !unlock_ff && $stable(bound_ff))
        else $error("locked protect register changed");
    a_zero_bound_off: assert property (
        bound_ff == 24'h000000 ##1 bound_ff == 24'h000000
        |-> !cmd_ff.protected_hit)
        else $error("protection with zero boundary");
    a_bound_page_hit: assert property (
        cmd_ff.kind != FAP_OP_NONE && $past(bound_ff) != 24'h000000 &&
        $stable(bound_ff) && cmd_ff.addr[23:11] <= bound_ff[23:11]
        |-> cmd_ff.protected_hit)
        else $error("page at or below boundary not protected");
    a_prot_needs_key: assert property (
        bound_ff != $past(bound_ff) |-> $past(key_ff == FAP_KEY_OPEN))
        else $error("protect written without key");

    c_key_open_write: cover property (
        key_ff == FAP_KEY_OPEN && wr && sel_prot);
    c_page_erase_hit: cover property (
        cmd_ff.kind == FAP_OP_PAGE_ERASE && cmd_ff.protected_hit);
    c_unlock_cleared: cover property ($fell(unlock_ff));
    c_unmapped_err: cover property (pslverr);
endmodule
